// ---- inc/spr_cfg.svh ----
`ifndef SPR_CFG_SVH
`define SPR_CFG_SVH

// ****************************************************************
// Register word addresses on the plain register port.
// ****************************************************************
`define SPR_ADDR_REQ 4'h0
`define SPR_ADDR_AXIS 4'h1
`define SPR_ADDR_PNUM 4'h2
`define SPR_ADDR_VAL1 4'h3
`define SPR_ADDR_VAL2_LO 4'h4
`define SPR_ADDR_VAL2_HI 4'h5
`define SPR_ADDR_STAT 4'h6
`define SPR_ADDR_MASK 4'h7
`define SPR_ADDR_CTRL 4'h8

// ****************************************************************
// Request codes.
// ****************************************************************
`define SPR_CODE_NONE 16'h0000
`define SPR_CODE_WR1 16'h0001
`define SPR_CODE_RD1 16'h0002
`define SPR_CODE_WR2 16'h0003
`define SPR_CODE_RD2 16'h0004
`define SPR_CODE_ERR 16'hFFFF

// ****************************************************************
// Field positions, limits and reset values.
// ****************************************************************
`define SPR_PTOP_MSB 15
`define SPR_PTOP_LSB 12
`define SPR_PGRP_MSB 11
`define SPR_PGRP_LSB 8
`define SPR_AXIS_MIN 16'h0001
`define SPR_AXIS_MAX_LARGE 16'h0020
`define SPR_AXIS_MAX_SMALL 16'h0010
`define SPR_CTRL_LARGE_BIT 0
`define SPR_CTRL_GCHK_BIT 1
`define SPR_STAT_DONE_BIT 0
`define SPR_STAT_ERR_BIT 1
`define SPR_STAT_BUSY_BIT 15
`define SPR_RST_WORD 16'h0000
`define SPR_RST_CTRL 16'h0003

// ****************************************************************
// Timing.
// ****************************************************************
`define SPR_CLK_MHZ 125
`define SPR_TIMEOUT_US 1000
`define SPR_TIMEOUT_CYC (`SPR_TIMEOUT_US * `SPR_CLK_MHZ)

`endif

// ---- inc/spr_pkg.sv ----
// ****************************************************************
// Shared types.
// ****************************************************************
package spr_pkg;
   // One-hot sequencer states used by both modules.
   typedef enum logic [1:0] {
      SPR_IDLE = 2'b01,
      SPR_BUSY = 2'b10
   } spr_state_t;
endpackage

// ---- rtl/spr_link.sv ----
`include "spr_cfg.svh"

// ****************************************************************
// Amplifier-side transfer engine with a response timeout.
// ****************************************************************
module spr_link #(
   parameter int unsigned TIMEOUT_CYC = `SPR_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic start_write,
   input wire logic start_double,
   input wire logic [5:0] start_axis,
   input wire logic [15:0] start_pnum,
   input wire logic [31:0] start_wdata,
   output logic amp_req,
   output logic amp_write,
   output logic amp_double,
   output logic [5:0] amp_axis,
   output logic [15:0] amp_pnum,
   output logic [31:0] amp_wdata,
   input wire logic amp_done,
   input wire logic amp_fail,
   input wire logic [31:0] amp_rdata,
   output logic fin,
   output logic fin_err,
   output logic [31:0] fin_rdata
);
   spr_pkg::spr_state_t st;
   logic [31:0] cnt;
   logic timeout;

   // The amplifier gets no answer window beyond the timeout count.
   always_comb begin
      timeout = (cnt == TIMEOUT_CYC - 32'd1);
   end

   // Request is held high until done, fail or timeout ends it.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st <= spr_pkg::SPR_IDLE;
         amp_req <= 1'b0;
         amp_write <= 1'b0;
         amp_double <= 1'b0;
         amp_axis <= 6'h00;
         amp_pnum <= 16'h0000;
         amp_wdata <= 32'h00000000;
         cnt <= 32'h00000000;
         fin <= 1'b0;
         fin_err <= 1'b0;
         fin_rdata <= 32'h00000000;
      end else begin
         fin <= 1'b0;
         unique case (st)
            spr_pkg::SPR_IDLE: begin
               if (start) begin
                  amp_req <= 1'b1;
                  amp_write <= start_write;
                  amp_double <= start_double;
                  amp_axis <= start_axis;
                  amp_pnum <= start_pnum;
                  amp_wdata <= start_wdata;
                  cnt <= 32'h00000000;
                  st <= spr_pkg::SPR_BUSY;
               end
            end
            spr_pkg::SPR_BUSY: begin
               if (amp_done || amp_fail || timeout) begin
                  amp_req <= 1'b0;
                  fin <= 1'b1;
                  fin_err <= !amp_done; // A done answer wins over a fail in one cycle.
                  fin_rdata <= amp_rdata;
                  st <= spr_pkg::SPR_IDLE;
               end else begin
                  cnt <= cnt + 32'd1;
               end
            end
         endcase
      end
   end
endmodule

// ---- rtl/spr_param_rw.sv ----
`include "spr_cfg.svh"

module spr_param_rw #(
   parameter int unsigned TIMEOUT_CYC = `SPR_TIMEOUT_CYC
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   output logic irq,
   output logic busy,
   output logic amp_req,
   output logic amp_write,
   output logic amp_double,
   output logic [5:0] amp_axis,
   output logic [15:0] amp_pnum,
   output logic [31:0] amp_wdata,
   input wire logic amp_done,
   input wire logic amp_fail,
   input wire logic [31:0] amp_rdata
);
   // ****************************************************************
   // Helpers.
   // ****************************************************************
   function automatic logic wr_hit(input logic wr, input logic [3:0] a, input logic [3:0] off);
      return wr && (a == off);
   endfunction

   // Accepted group digits are 0 to 5 and 9, A, B, C with a zero top digit.
   function automatic logic grp_ok(input logic [15:0] p);
      logic [3:0] g;
      g = p[`SPR_PGRP_MSB:`SPR_PGRP_LSB];
      return (p[`SPR_PTOP_MSB:`SPR_PTOP_LSB] == 4'h0) &&
             ((g <= 4'h5) || ((g >= 4'h9) && (g <= 4'hC)));
   endfunction

   spr_pkg::spr_state_t state;
   logic [15:0] code, axis, pnum, val1, val2_lo, val2_hi, mask, ctrl;
   logic [1:0] stat, stat_set, stat_clr, next_stat;
   logic op_read, op_double;
   logic idle, code_op, args_ok, go_start, go_reject, accept;
   logic is_write, is_double;
   logic [15:0] axis_max;
   logic link_fin, link_err;
   logic [31:0] link_rdata, start_wdata;

   // ****************************************************************
   // Request decode.
   // ****************************************************************

   // Decides whether the posted code starts, is refused, or waits.
   always_comb begin
      idle = (state == spr_pkg::SPR_IDLE);
      code_op = (code >= `SPR_CODE_WR1) && (code <= `SPR_CODE_RD2);
      axis_max = ctrl[`SPR_CTRL_LARGE_BIT] ? `SPR_AXIS_MAX_LARGE : `SPR_AXIS_MAX_SMALL;
      args_ok = (axis >= `SPR_AXIS_MIN) && (axis <= axis_max) &&
                (!ctrl[`SPR_CTRL_GCHK_BIT] || grp_ok(pnum));
      go_start = idle && code_op && args_ok;
      go_reject = idle && (code != `SPR_CODE_NONE) && (code != `SPR_CODE_ERR) && !go_start;
      accept = idle && !go_start && !go_reject;
      is_write = (code == `SPR_CODE_WR1) || (code == `SPR_CODE_WR2);
      is_double = (code == `SPR_CODE_WR2) || (code == `SPR_CODE_RD2);
      start_wdata = is_double ? {val2_hi, val2_lo} : {16'h0000, val1};
   end

   // ****************************************************************
   // Sequencer.
   // ****************************************************************

   // Tracks one outstanding transfer and its kind.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         state <= spr_pkg::SPR_IDLE;
         op_read <= 1'b0;
         op_double <= 1'b0;
         busy <= 1'b0;
      end else begin
         unique case (state)
            spr_pkg::SPR_IDLE: begin
               if (go_start) begin
                  state <= spr_pkg::SPR_BUSY;
                  op_read <= !is_write;
                  op_double <= is_double;
                  busy <= 1'b1;
               end
            end
            spr_pkg::SPR_BUSY: begin
               if (link_fin) begin
                  state <= spr_pkg::SPR_IDLE;
                  busy <= 1'b0;
               end
            end
         endcase
      end
   end

   // Transfer engine toward the amplifier.
   spr_link #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_link (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .start(go_start),
      .start_write(is_write),
      .start_double(is_double),
      .start_axis(axis[5:0]),
      .start_pnum(pnum),
      .start_wdata(start_wdata),
      .amp_req(amp_req),
      .amp_write(amp_write),
      .amp_double(amp_double),
      .amp_axis(amp_axis),
      .amp_pnum(amp_pnum),
      .amp_wdata(amp_wdata),
      .amp_done(amp_done),
      .amp_fail(amp_fail),
      .amp_rdata(amp_rdata),
      .fin(link_fin),
      .fin_err(link_err),
      .fin_rdata(link_rdata)
   );

   // ****************************************************************
   // Registers.
   // ****************************************************************

   // Request code: completion and refusal override software while they happen.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         code <= `SPR_RST_WORD;
      end else if (link_fin) begin
         code <= link_err ? `SPR_CODE_ERR : `SPR_CODE_NONE;
      end else if (go_reject) begin
         code <= `SPR_CODE_ERR;
      end else if (accept && wr_hit(reg_wr, reg_addr, `SPR_ADDR_REQ)) begin
         code <= reg_wdata;
      end
   end

   // Operands are frozen while a transfer runs; read results land here.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         axis <= `SPR_RST_WORD;
         pnum <= `SPR_RST_WORD;
         val1 <= `SPR_RST_WORD;
         val2_lo <= `SPR_RST_WORD;
         val2_hi <= `SPR_RST_WORD;
      end else if (link_fin) begin
         if (!link_err && op_read && !op_double) begin
            val1 <= link_rdata[15:0];
         end
         if (!link_err && op_read && op_double) begin
            val2_lo <= link_rdata[15:0];
            val2_hi <= link_rdata[31:16];
         end
      end else if (accept) begin
         if (wr_hit(reg_wr, reg_addr, `SPR_ADDR_AXIS)) axis <= reg_wdata;
         if (wr_hit(reg_wr, reg_addr, `SPR_ADDR_PNUM)) pnum <= reg_wdata;
         if (wr_hit(reg_wr, reg_addr, `SPR_ADDR_VAL1)) val1 <= reg_wdata;
         if (wr_hit(reg_wr, reg_addr, `SPR_ADDR_VAL2_LO)) val2_lo <= reg_wdata;
         if (wr_hit(reg_wr, reg_addr, `SPR_ADDR_VAL2_HI)) val2_hi <= reg_wdata;
      end
   end

   // Control and mask registers.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl <= `SPR_RST_CTRL;
         mask <= `SPR_RST_WORD;
      end else begin
         if (wr_hit(reg_wr, reg_addr, `SPR_ADDR_CTRL)) ctrl <= {14'h0000, reg_wdata[1:0]};
         if (wr_hit(reg_wr, reg_addr, `SPR_ADDR_MASK)) mask <= {14'h0000, reg_wdata[1:0]};
      end
   end

   // ****************************************************************
   // Interrupt status.
   // ****************************************************************

   // Sticky events; a set in the same cycle as a clear wins.
   always_comb begin
      stat_set = 2'b00;
      stat_set[`SPR_STAT_DONE_BIT] = link_fin && !link_err;
      stat_set[`SPR_STAT_ERR_BIT] = (link_fin && link_err) || go_reject;
      stat_clr = wr_hit(reg_wr, reg_addr, `SPR_ADDR_STAT) ? reg_wdata[1:0] : 2'b00;
      next_stat = (stat & ~stat_clr) | stat_set;
   end

   // Status register and the level interrupt it drives.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         stat <= 2'b00;
         irq <= 1'b0;
      end else begin
         stat <= next_stat;
         irq <= |(next_stat & mask[1:0]);
      end
   end

   // ****************************************************************
   // Read port.
   // ****************************************************************

   // Read data stand for one cycle after the strobe and read zero otherwise.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !reg_rd) begin
         reg_rdata <= 16'h0000;
      end else begin
         unique case (reg_addr)
            `SPR_ADDR_REQ: reg_rdata <= code;
            `SPR_ADDR_AXIS: reg_rdata <= axis;
            `SPR_ADDR_PNUM: reg_rdata <= pnum;
            `SPR_ADDR_VAL1: reg_rdata <= val1;
            `SPR_ADDR_VAL2_LO: reg_rdata <= val2_lo;
            `SPR_ADDR_VAL2_HI: reg_rdata <= val2_hi;
            `SPR_ADDR_STAT: reg_rdata <= {busy, 13'h0000, stat};
            `SPR_ADDR_MASK: reg_rdata <= mask;
            `SPR_ADDR_CTRL: reg_rdata <= ctrl;
            default: reg_rdata <= 16'h0000;
         endcase
      end
   end

   // ****************************************************************
   // Checks.
   // ****************************************************************

   // Only legal codes ever launch a transfer.
   chk_start_code_legal: assert property (@(posedge clk_sys) disable iff (sys_rst)
      go_start |-> (code >= `SPR_CODE_WR1) && (code <= `SPR_CODE_RD2) ##1 amp_req)
      else $error("transfer started with an illegal code");

   // A one-word read result appears in the one-word value register.
   chk_read_value_store: assert property (@(posedge clk_sys) disable iff (sys_rst)
      link_fin && !link_err && op_read && !op_double |=> val1 == $past(link_rdata[15:0]))
      else $error("one-word read result not stored");

   // Success clears the code and raises the done flag together.
   chk_done_clears_code: assert property (@(posedge clk_sys) disable iff (sys_rst)
      link_fin && !link_err |=> (code == `SPR_CODE_NONE) && stat[`SPR_STAT_DONE_BIT] && !busy)
      else $error("completion did not clear the request code");

   // Failure writes minus one and raises the error flag.
   chk_fail_sets_error: assert property (@(posedge clk_sys) disable iff (sys_rst)
      link_fin && link_err |=> (code == `SPR_CODE_ERR) && stat[`SPR_STAT_ERR_BIT])
      else $error("failure did not mark the request code");

   // An axis of zero with a legal code is refused without touching the amplifier.
   chk_axis_refused: assert property (@(posedge clk_sys) disable iff (sys_rst)
      idle && code_op && (axis == 16'h0000) |=> (code == `SPR_CODE_ERR) && !amp_req)
      else $error("axis zero was not refused");

   // A nonzero top digit is refused when group checking is on.
   chk_group_refused: assert property (@(posedge clk_sys) disable iff (sys_rst)
      idle && code_op && ctrl[`SPR_CTRL_GCHK_BIT] && (pnum[15:12] != 4'h0)
      |=> code == `SPR_CODE_ERR)
      else $error("bad parameter number was not refused");

   // Operands hold still for the whole transfer.
   chk_busy_operands_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
      busy && !link_fin |=> $stable(axis) && $stable(pnum) && $stable(val1) && $stable(code))
      else $error("operand changed during a transfer");

   // An unmasked sticky flag raises the interrupt on the next edge.
   chk_irq_follows_mask: assert property (@(posedge clk_sys) disable iff (sys_rst)
      ((stat & mask[1:0]) != 2'b00) && !wr_hit(reg_wr, reg_addr, `SPR_ADDR_STAT) |=> irq)
      else $error("interrupt missing for an unmasked flag");
endmodule

// ---- testbench/spr_amp_model.sv ----
// ****************************************************************
// Behavioural amplifier answering parameter transfers.
// ****************************************************************
module spr_amp_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic amp_req,
   input wire logic [15:0] amp_pnum,
   input wire logic [3:0] delay,
   input wire logic fail_mode,
   input wire logic mute,
   output logic amp_done,
   output logic amp_fail,
   output logic [31:0] amp_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] wait_cnt;
   logic answered;
   logic answer_now;

   // The answer cycle of the current request.
   assign answer_now = amp_req && !answered && !mute && (wait_cnt == delay);

   // Waits the set delay, then answers once; fail_mode turns the answer into a refusal.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         amp_done <= 1'b0;
         amp_fail <= 1'b0;
         answered <= 1'b0;
         wait_cnt <= 4'h0;
      end else begin
         amp_done <= answer_now && !fail_mode;
         amp_fail <= answer_now && fail_mode;
         if (!amp_req) begin
            answered <= 1'b0;
            wait_cnt <= 4'h0;
         end else if (answer_now) begin
            answered <= 1'b1;
         end else if (!answered && !mute) begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end

   // Read data is valid only in the cycle after the answer cycle, while amp_done is high; it toggles otherwise.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         amp_rdata <= 32'h0;
      end else if (answer_now) begin
         amp_rdata <= {amp_pnum ^ 16'hFF00, amp_pnum ^ 16'h00FF};
      end else begin
         amp_rdata <= ~amp_rdata;
      end
   end
endmodule

// ---- testbench/tb_servo_param_rw_request.sv ----
`include "spr_cfg.svh"

// ****************************************************************
// Self-checking bench for the parameter request block.
// ****************************************************************
module tb_servo_param_rw_request;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, sys_rst, reg_wr, reg_rd, irq, busy, fail_mode, mute;
   logic amp_req, amp_write, amp_double, amp_done, amp_fail, cap_seen, cap_write, cap_double;
   logic cap_clr;
   logic [3:0] reg_addr, delay;
   logic [5:0] amp_axis, cap_axis;
   logic [15:0] reg_wdata, reg_rdata, amp_pnum, cap_pnum, rv;
   logic [31:0] amp_wdata, amp_rdata, cap_wdata;
   logic [15:0] pn [4] = '{16'h0005, 16'h0A10, 16'h0C7F, 16'h0910};
   logic [15:0] bad [6][3] = '{'{1, 0, 16'h0100}, '{1, 33, 16'h0100}, '{5, 1, 16'h0100},
      '{2, 1, 16'h1100}, '{2, 1, 16'h0600}, '{2, 1, 16'h0D00}};
   int n_errors, comparisons;

   spr_param_rw #(.TIMEOUT_CYC(20)) uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .busy(busy), .amp_req(amp_req), .amp_write(amp_write),
      .amp_double(amp_double), .amp_axis(amp_axis), .amp_pnum(amp_pnum),
      .amp_wdata(amp_wdata), .amp_done(amp_done), .amp_fail(amp_fail), .amp_rdata(amp_rdata));
   spr_amp_model amp (.clk_sys(clk_sys), .sys_rst(sys_rst), .amp_req(amp_req),
      .amp_pnum(amp_pnum), .delay(delay), .fail_mode(fail_mode), .mute(mute),
      .amp_done(amp_done), .amp_fail(amp_fail), .amp_rdata(amp_rdata));

   // Free-running system clock.
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // Captures what the block sends to the amplifier; cap_clr empties the record.
   always @(posedge clk_sys) begin
      if (cap_clr) begin
         cap_seen <= 1'b0;
      end else if (amp_req === 1'b1) begin
         cap_seen <= 1'b1;
         cap_write <= amp_write;
         cap_double <= amp_double;
         cap_axis <= amp_axis;
         cap_pnum <= amp_pnum;
         cap_wdata <= amp_wdata;
      end
   end

   // Compares one value and reports a mismatch.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   // One-cycle register write.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read and compare of the data in the next cycle.
   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
      check(rv, exp);
   endtask

   // Loads axis and parameter number, then posts a code.
   task automatic post_req(input logic [15:0] code, input logic [15:0] ax, input logic [15:0] p);
      cap_clr <= 1'b1;
      @(posedge clk_sys);
      cap_clr <= 1'b0;
      wr(`SPR_ADDR_AXIS, ax);
      wr(`SPR_ADDR_PNUM, p);
      wr(`SPR_ADDR_REQ, code);
      repeat (3) @(posedge clk_sys);
   endtask

   // Waits for the transfer to finish under a bounded count; busy is read off the edge.
   task automatic wait_done();
      #1;
      for (int i = 0; i < 200 && busy === 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      check(busy, 1'b0);
      repeat (2) @(posedge clk_sys);
      #1;
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic close_out();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      close_out();
   end

   // Main sequence.
   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 22'h0};
      {delay, fail_mode, mute, cap_clr} = 7'h0;
      n_errors = 0;
      comparisons = 0;
      repeat (4) @(posedge clk_sys);
      sys_rst <= 1'b0;
      for (int a = 0; a < 10; a++) rchk(a[3:0], (a == 8) ? 16'h0003 : 16'h0000);
      check({busy, irq, amp_req}, 3'h0);
      wr(`SPR_ADDR_MASK, 16'h0003);
      wr(`SPR_ADDR_VAL1, 16'h1234);
      wr(`SPR_ADDR_VAL2_LO, 16'h5678);
      wr(`SPR_ADDR_VAL2_HI, 16'h9ABC);
      for (int c = 1; c <= 4; c++) begin
         post_req(c[15:0], 16'h0020, pn[c-1]);
         wait_done();
         check({cap_seen, cap_write, cap_double}, {1'b1, c[0], c > 2});
         check({cap_axis, cap_pnum}, {6'h20, pn[c-1]});
         if (c == 1) check(cap_wdata, 32'h0000_1234);
         if (c == 3) check(cap_wdata, 32'h9ABC_5678);
         if (c == 2) rchk(`SPR_ADDR_VAL1, pn[1] ^ 16'h00FF);
         if (c == 4) rchk(`SPR_ADDR_VAL2_LO, pn[3] ^ 16'h00FF);
         if (c == 4) rchk(`SPR_ADDR_VAL2_HI, pn[3] ^ 16'hFF00);
         check(irq, 1'b1);
         rchk(`SPR_ADDR_REQ, 16'h0000);
         rchk(`SPR_ADDR_STAT, 16'h0001);
         wr(`SPR_ADDR_STAT, 16'h0003);
         repeat (2) @(posedge clk_sys);
         #1 check(irq, 1'b0);
      end
      fail_mode = 1'b1;
      post_req(16'h0002, 16'h0005, 16'h0100);
      wait_done();
      rchk(`SPR_ADDR_REQ, 16'hFFFF);
      rchk(`SPR_ADDR_STAT, 16'h0002);
      check(irq, 1'b1);
      {fail_mode, mute} = 2'b01;
      post_req(16'h0001, 16'h0005, 16'h0100);
      wait_done();
      rchk(`SPR_ADDR_REQ, 16'hFFFF);
      mute = 1'b0;
      for (int k = 0; k < 6; k++) begin
         post_req(bad[k][0], bad[k][1], bad[k][2]);
         wait_done();
         rchk(`SPR_ADDR_REQ, 16'hFFFF);
         check(cap_seen, 1'b0);
      end
      wr(`SPR_ADDR_CTRL, 16'h0002);
      post_req(16'h0001, 16'h0011, 16'h0100);
      wait_done();
      rchk(`SPR_ADDR_REQ, 16'hFFFF);
      post_req(16'h0001, 16'h0010, 16'h0100);
      wait_done();
      rchk(`SPR_ADDR_REQ, 16'h0000);
      wr(`SPR_ADDR_CTRL, 16'h0001);
      post_req(16'h0001, 16'h0001, 16'h1D00);
      wait_done();
      rchk(`SPR_ADDR_REQ, 16'h0000);
      check({cap_seen, cap_pnum}, {1'b1, 16'h1D00});
      wr(`SPR_ADDR_CTRL, 16'h0003);
      wr(`SPR_ADDR_STAT, 16'h0003);
      wr(`SPR_ADDR_MASK, 16'h0000);
      delay = 4'hA;
      post_req(16'h0002, 16'h0003, 16'h0100);
      check(busy, 1'b1);
      wr(`SPR_ADDR_AXIS, 16'h0007);
      wr(`SPR_ADDR_PNUM, 16'h0200);
      wr(`SPR_ADDR_REQ, 16'h0001);
      wait_done();
      rchk(`SPR_ADDR_AXIS, 16'h0003);
      rchk(`SPR_ADDR_PNUM, 16'h0100);
      rchk(`SPR_ADDR_REQ, 16'h0000);
      check({cap_axis, irq}, {6'h03, 1'b0});
      rchk(`SPR_ADDR_STAT, 16'h0001);
      close_out();
   end
endmodule
